// *** core/mpp_pkg.sv ***
/*
  shared constants, types and register map of the multiphase pwm phasing block.
  assumes one 40 MHz clock and a plain register port.
*/
//Contract
//R01: loop one 3/2/1 phases, loop two off/one
//R02: phases outside the configuration are disabled
//R03: active phases evenly spaced per period
//R04: start-up pin level marks phase present
//R05: auto-detect runs detected phases within configuration
//R06: board grounds unused pins for auto-detect
//R07: per-loop software switching period
//R08: outputs high, low or floating
//R09: float when disabled, before/after ramps
//R10: per-loop error adc sample feeds control
//R11: input-current adc code is captured
//R12: four halving input-current full-scale ranges
//R13: code zero 0 V, one 500 mV, +10 mV
//R14: detection latched once after reset
package mpp_pkg;
  localparam int ADDR_W = 4;               // register address width
  localparam int DATA_W = 16;              // register data width
  localparam int ERR_W  = 10;              // error adc word
  localparam int IIN_W  = 12;              // input-current adc word
  localparam int MV_W   = 12;              // millivolt width
  // register offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_FSW1   = 4'h1;
  localparam logic [3:0] OFS_FSW2   = 4'h2;
  localparam logic [3:0] OFS_VID1   = 4'h3;
  localparam logic [3:0] OFS_VID2   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_TGT1   = 4'h6;
  localparam logic [3:0] OFS_TGT2   = 4'h7;
  localparam logic [3:0] OFS_ERR1   = 4'h8;
  localparam logic [3:0] OFS_ERR2   = 4'h9;
  localparam logic [3:0] OFS_IIN    = 4'ha;
  // control field positions
  localparam int CTRL_CFG_LSB  = 0;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_RNG_LSB  = 4;
  localparam int CTRL_RUN_BIT  = 6;
  // status field positions
  localparam int ST_DET_LSB  = 0;
  localparam int ST_N1_LSB   = 4;
  localparam int ST_L2_BIT   = 6;
  localparam int ST_DONE_BIT = 7;
  localparam int ST_RUN_LSB  = 8;
  // reset values
  localparam logic [2:0] RST_CFG = 3'h3;
  localparam logic [7:0] RST_FSW = 8'h64;
  localparam logic [7:0] RST_VID = 8'h00;
  // target decode
  localparam logic [MV_W-1:0] VID_BASE_MV = 12'h1f4;
  localparam logic [MV_W-1:0] VID_STEP_MV = 12'h00a;
  // input-current scale, milliamps at the widest range
  localparam logic [15:0] IIN_FS_MA = 16'hf424;
  // timing
  localparam int CLK_NS      = 25;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
  // loop configurations
  typedef enum logic [2:0] {
    CFG_3P0 = 3'h0, CFG_2P0 = 3'h1, CFG_1P0 = 3'h2,
    CFG_3P1 = 3'h3, CFG_2P1 = 3'h4, CFG_1P1 = 3'h5
  } mpp_cfg_e;
  // run sequence, one-hot
  typedef enum logic [3:0] {
    RUN_IDLE = 4'h1, RUN_UP = 4'h2, RUN_ON = 4'h4, RUN_DOWN = 4'h8
  } mpp_run_e;
  // four pwm pins: level and drive enable
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } mpp_pins_s;
  // control register
  typedef struct packed {
    logic       run_on;
    logic [1:0] iin_range;
    logic       auto_det;
    logic [2:0] cfg;
  } mpp_ctrl_s;
endpackage

// *** core/mpp_adc_capture.sv ***
/*
  holds the latest word of an external converter.
  assumes the converter's valid strobe is synchronous to the clock.
*/
`timescale 1ns/10ps
module mpp_adc_capture #(
  parameter int W = 10
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_code,
  output logic      [W-1:0] o_value
);
  // sample on each valid strobe
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_value <= '0;
    end
    else if (i_valid)
    begin
      o_value <= i_code;
    end
  end
endmodule

// *** core/mpp_phase_pwm.sv ***
/*
  one loop's carrier and up to three interleaved pulse trains.
  assumes period and duty are stable in clock cycles.
*/
`timescale 1ns/10ps
module mpp_phase_pwm (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [7:0] i_period,
  input  wire logic [7:0] i_duty,
  input  wire logic [1:0] i_nph,
  output logic      [2:0] o_level
);
  logic [7:0]  cnt;           // carrier position
  logic [16:0] p3;            // period * 171, /512 gives period/3
  logic [16:0] p23;           // 2 * period * 171
  logic [7:0]  off [3];       // per-phase start offsets

  // carrier counter, restarts when stopped
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= 8'h00;
    end
    else if (!i_run || cnt + 8'h01 >= i_period)
    begin
      cnt <= 8'h00;
    end
    else
    begin
      cnt <= cnt + 8'h01;
    end
  end

  // exact for periods below 256
  assign p3  = {9'h000, i_period} * 17'h000ab;
  assign p23 = {8'h00, i_period, 1'b0} * 17'h000ab;
  assign off[0] = 8'h00;
  assign off[1] = (i_nph == 2'h2) ? {1'b0, i_period[7:1]}
                                  : p3[16:9];  // see R03
  assign off[2] = p23[16:9];                   // see R03

  // each phase compares its shifted carrier with duty
  for (genvar k = 0; k < 3; k++)
  begin : g_ph
    logic [7:0] loc;
    assign loc = (cnt >= off[k]) ? cnt - off[k] : cnt + i_period - off[k];
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
      if (i_rst)
      begin
        o_level[k] <= 1'b0;
      end
      else
      begin
        o_level[k] <= i_run && (2'(k) < i_nph) && (loc < i_duty);
      end
    end
  end
endmodule

// *** core/mpp_top.sv ***
/*
  phase management of a dual-loop multiphase buck controller:
  loop configuration, start-up phase detection, interleaved pwm,
  per-loop switching period, target decode, ramps, adc capture.
  assumes synchronous inputs, one 40 MHz clock and a plain
  register port with read data one cycle after the read strobe.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module mpp_top (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rst,
  input  wire logic                           i_en,
  input  wire logic [3:0]                     i_pwm_present,
  input  wire logic [7:0]                     i_duty1,
  input  wire logic [7:0]                     i_duty2,
  input  wire logic                           i_err1_valid,
  input  wire logic [mpp_pkg::ERR_W-1:0]      i_err1_code,
  input  wire logic                           i_err2_valid,
  input  wire logic [mpp_pkg::ERR_W-1:0]      i_err2_code,
  input  wire logic                           i_iin_valid,
  input  wire logic [mpp_pkg::IIN_W-1:0]      i_iin_code,
  input  wire logic [mpp_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [mpp_pkg::DATA_W-1:0]     i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [mpp_pkg::DATA_W-1:0]     o_rdata,
  output mpp_pkg::mpp_pins_s                  o_pwm,
  output logic      [mpp_pkg::ERR_W-1:0]      o_err1,
  output logic      [mpp_pkg::ERR_W-1:0]      o_err2,
  output logic      [mpp_pkg::MV_W-1:0]       o_ref1_mv,
  output logic      [mpp_pkg::MV_W-1:0]       o_ref2_mv,
  output logic      [15:0]                    o_iin_ma
);
  mpp_pkg::mpp_ctrl_s          ctrl;          // control register
  logic [7:0]                  fsw1;          // loop one period, cycles
  logic [7:0]                  fsw2;          // loop two period, cycles
  logic [7:0]                  vid1;          // loop one code
  logic [7:0]                  vid2;          // loop two code
  logic [3:0]                  det;           // latched presence
  logic                        det_done;      // detection taken
  logic [1:0]                  max1;          // loop one limit
  logic                        has2;          // loop two allowed
  logic [1:0]                  det_cnt;       // contiguous found phases
  logic [1:0]                  next_n1;       // loop one phases
  logic                        next_l2;       // loop two runs
  logic [1:0]                  n1;            // registered phase count
  logic                        l2;            // registered loop two
  mpp_pkg::mpp_run_e           run;           // run sequence state
  mpp_pkg::mpp_run_e           next_run;      // its next value
  logic [mpp_pkg::MV_W-1:0]    tgt1;          // decoded target one
  logic [mpp_pkg::MV_W-1:0]    tgt2;          // decoded target two
  logic [5:0]                  step_cnt;      // ramp step timer
  logic                        step_tick;     // one-cycle ramp step
  logic                        up_done;       // both refs at target
  logic                        down_done;     // both refs at zero
  logic [2:0]                  lvl1;          // loop one pulses
  logic [2:0]                  lvl2;          // loop two pulses
  logic                        drive;         // pins driven
  logic [27:0]                 iin_prod;      // code times full scale
  logic [mpp_pkg::ERR_W-1:0]   err1;          // captured error one
  logic [mpp_pkg::ERR_W-1:0]   err2;          // captured error two
  logic [mpp_pkg::IIN_W-1:0]   iin_code;      // captured current code

  // code to millivolts
  function automatic logic [11:0] vid_to_mv(input logic [7:0] code);
    logic [11:0] steps;
    steps = {4'h0, code} - 12'h001;
    if (code == 8'h00)
    begin
      return 12'h000;                                  // see R13
    end
    return mpp_pkg::VID_BASE_MV
           + 12'(steps * mpp_pkg::VID_STEP_MV);        // see R13
  endfunction

  // one millivolt toward the goal
  function automatic logic [11:0] slew(input logic [11:0] cur,
                                       input logic [11:0] goal);
    if (cur < goal)
    begin
      return cur + 12'h001;
    end
    else if (cur > goal)
    begin
      return cur - 12'h001;
    end
    return cur;
  endfunction

  // register writes
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl <= '{run_on: 1'b0, iin_range: 2'h0, auto_det: 1'b0,
                cfg: mpp_pkg::RST_CFG};
      fsw1 <= mpp_pkg::RST_FSW;
      fsw2 <= mpp_pkg::RST_FSW;
      vid1 <= mpp_pkg::RST_VID;
      vid2 <= mpp_pkg::RST_VID;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        mpp_pkg::OFS_CTRL:
        begin
          ctrl.cfg       <= i_wdata[mpp_pkg::CTRL_CFG_LSB +: 3];
          ctrl.auto_det  <= i_wdata[mpp_pkg::CTRL_AUTO_BIT];
          ctrl.iin_range <= i_wdata[mpp_pkg::CTRL_RNG_LSB +: 2]; // see R12
          ctrl.run_on    <= i_wdata[mpp_pkg::CTRL_RUN_BIT];
        end
        mpp_pkg::OFS_FSW1: fsw1 <= i_wdata[7:0];       // see R07
        mpp_pkg::OFS_FSW2: fsw2 <= i_wdata[7:0];       // see R07
        mpp_pkg::OFS_VID1: vid1 <= i_wdata[7:0];
        mpp_pkg::OFS_VID2: vid2 <= i_wdata[7:0];
        default:
        begin
          // read-only or unmapped: ignored
        end
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= '0;
    end
    else if (!i_rd)
    begin
      o_rdata <= '0;
    end
    else
    begin
      unique case (i_addr)
        mpp_pkg::OFS_CTRL:   o_rdata <= {9'h000, ctrl};
        mpp_pkg::OFS_FSW1:   o_rdata <= {8'h00, fsw1};
        mpp_pkg::OFS_FSW2:   o_rdata <= {8'h00, fsw2};
        mpp_pkg::OFS_VID1:   o_rdata <= {8'h00, vid1};
        mpp_pkg::OFS_VID2:   o_rdata <= {8'h00, vid2};
        mpp_pkg::OFS_STATUS:
        begin
          o_rdata <= '0;
          o_rdata[mpp_pkg::ST_DET_LSB +: 4] <= det;
          o_rdata[mpp_pkg::ST_N1_LSB +: 2]  <= n1;
          o_rdata[mpp_pkg::ST_L2_BIT]       <= l2;
          o_rdata[mpp_pkg::ST_DONE_BIT]     <= det_done;
          o_rdata[mpp_pkg::ST_RUN_LSB +: 4] <= run;
        end
        mpp_pkg::OFS_TGT1:   o_rdata <= {4'h0, tgt1};
        mpp_pkg::OFS_TGT2:   o_rdata <= {4'h0, tgt2};
        mpp_pkg::OFS_ERR1:   o_rdata <= {6'h00, err1};
        mpp_pkg::OFS_ERR2:   o_rdata <= {6'h00, err2};
        mpp_pkg::OFS_IIN:    o_rdata <= o_iin_ma;
        default:             o_rdata <= '0;     // unmapped reads zero
      endcase
    end
  end

  // phase presence caught once after reset release
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      det      <= 4'h0;
      det_done <= 1'b0;
    end
    else if (!det_done)
    begin
      det      <= i_pwm_present;                       // see R04, R14
      det_done <= 1'b1;                                // see R14
    end
  end

  // configuration limits and detected phase count
  always_comb
  begin
    max1 = 2'h1;
    has2 = 1'b0;
    unique case (ctrl.cfg)
      mpp_pkg::CFG_3P0: max1 = 2'h3;                   // see R01
      mpp_pkg::CFG_2P0: max1 = 2'h2;
      mpp_pkg::CFG_1P0: max1 = 2'h1;
      mpp_pkg::CFG_3P1:
      begin
        max1 = 2'h3;
        has2 = 1'b1;
      end
      mpp_pkg::CFG_2P1:
      begin
        max1 = 2'h2;
        has2 = 1'b1;
      end
      mpp_pkg::CFG_1P1:
      begin
        max1 = 2'h1;
        has2 = 1'b1;
      end
      default:
      begin
        // illegal codes fall back to one phase
        max1 = 2'h1;
        has2 = 1'b0;
      end
    endcase
    // unused pins are grounded so they read absent; see R06
    det_cnt = !det[0] ? 2'h0 : !det[1] ? 2'h1 : !det[2] ? 2'h2 : 2'h3;
    if (ctrl.auto_det)
    begin
      next_n1 = (det_cnt < max1) ? det_cnt : max1;     // see R05
      next_l2 = has2 && det[3];                        // see R05
    end
    else
    begin
      next_n1 = max1;
      next_l2 = has2;
    end
  end

  // registered phase selection
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      n1 <= 2'h0;
      l2 <= 1'b0;
    end
    else
    begin
      n1 <= next_n1;
      l2 <= next_l2;
    end
  end

  // ramp step timer
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      step_cnt <= 6'h00;
    end
    else if (step_tick)
    begin
      step_cnt <= 6'h00;
    end
    else
    begin
      step_cnt <= step_cnt + 6'h01;
    end
  end
  assign step_tick = (step_cnt == 6'(mpp_pkg::RAMP_STEP_CYC - 1));

  // target decode
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      tgt1 <= 12'h000;
      tgt2 <= 12'h000;
    end
    else
    begin
      tgt1 <= vid_to_mv(vid1);
      tgt2 <= vid_to_mv(vid2);
    end
  end
  assign up_done   = (o_ref1_mv == tgt1) && (o_ref2_mv == tgt2);
  assign down_done = (o_ref1_mv == 12'h000) && (o_ref2_mv == 12'h000);

  // run sequence next state
  always_comb
  begin
    next_run = run;
    unique case (run)
      mpp_pkg::RUN_IDLE:
      begin
        if (i_en && det_done && ctrl.run_on)
        begin
          next_run = mpp_pkg::RUN_UP;
        end
      end
      mpp_pkg::RUN_UP:
      begin
        if (!i_en)
        begin
          next_run = mpp_pkg::RUN_IDLE;                // see R09
        end
        else if (!ctrl.run_on)
        begin
          next_run = mpp_pkg::RUN_DOWN;
        end
        else if (up_done)
        begin
          next_run = mpp_pkg::RUN_ON;
        end
      end
      mpp_pkg::RUN_ON:
      begin
        if (!i_en)
        begin
          next_run = mpp_pkg::RUN_IDLE;                // see R09
        end
        else if (!ctrl.run_on)
        begin
          next_run = mpp_pkg::RUN_DOWN;
        end
      end
      mpp_pkg::RUN_DOWN:
      begin
        if (!i_en || down_done)
        begin
          next_run = mpp_pkg::RUN_IDLE;                // see R09
        end
      end
      default: next_run = mpp_pkg::RUN_IDLE;
    endcase
  end

  // run sequence state
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      run <= mpp_pkg::RUN_IDLE;
    end
    else
    begin
      run <= next_run;
    end
  end

  // references slew one millivolt per step
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ref1_mv <= 12'h000;
      o_ref2_mv <= 12'h000;
    end
    else if (next_run == mpp_pkg::RUN_IDLE)
    begin
      o_ref1_mv <= 12'h000;
      o_ref2_mv <= 12'h000;
    end
    else if (step_tick && run == mpp_pkg::RUN_DOWN)
    begin
      o_ref1_mv <= slew(o_ref1_mv, 12'h000);
      o_ref2_mv <= slew(o_ref2_mv, 12'h000);
    end
    else if (step_tick)
    begin
      o_ref1_mv <= slew(o_ref1_mv, tgt1);
      o_ref2_mv <= slew(o_ref2_mv, tgt2);
    end
  end

  assign drive = (next_run != mpp_pkg::RUN_IDLE);

  // loop one, up to three phases
  mpp_phase_pwm u_pwm1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (drive),
    .i_period  (fsw1),
    .i_duty    (i_duty1),
    .i_nph     (n1),
    .o_level   (lvl1)
  );

  // loop two, one phase at its own period
  mpp_phase_pwm u_pwm2 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (drive && l2),
    .i_period  (fsw2),
    .i_duty    (i_duty2),
    .i_nph     ({1'b0, l2}),
    .o_level   (lvl2)
  );

  // pin drivers: float unless running and selected
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pwm <= '0;                                     // see R09
    end
    else
    begin
      o_pwm.level <= {lvl2[0], lvl1};                  // see R08
      o_pwm.oe[0] <= drive && (next_n1 >= 2'h1);       // see R02, R09
      o_pwm.oe[1] <= drive && (next_n1 >= 2'h2);       // see R02
      o_pwm.oe[2] <= drive && (next_n1 == 2'h3);       // see R02
      o_pwm.oe[3] <= drive && next_l2;                 // see R02, R01
    end
  end

  // error converters feeding the control law, and the input-current converter
  mpp_adc_capture #(.W(mpp_pkg::ERR_W)) u_err1 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_valid   (i_err1_valid),                         // see R10
    .i_code    (i_err1_code),
    .o_value   (err1)
  );
  mpp_adc_capture #(.W(mpp_pkg::ERR_W)) u_err2 (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_valid   (i_err2_valid),                         // see R10
    .i_code    (i_err2_code),
    .o_value   (err2)
  );
  mpp_adc_capture #(.W(mpp_pkg::IIN_W)) u_iin (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_valid   (i_iin_valid),                          // see R11
    .i_code    (i_iin_code),
    .o_value   (iin_code)
  );
  assign o_err1 = err1;
  assign o_err2 = err2;

  // current scaling: full scale halves per range step
  assign iin_prod = {16'h0000, iin_code} * {12'h000, mpp_pkg::IIN_FS_MA};
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_iin_ma <= 16'h0000;
    end
    else
    begin
      o_iin_ma <= 16'(iin_prod >> (mpp_pkg::IIN_W
                   + {30'h0, ctrl.iin_range}));        // see R12
    end
  end
endmodule

// *** verification/mpp_top_asserts.sv ***
/*
  port checker for the phasing block: pin drive, captures, ramp.
  assumes it is bound into mpp_top and sees only its ports.
*/
`timescale 1ns/10ps
module mpp_top_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_err1_valid,
  input wire logic [mpp_pkg::ERR_W-1:0] i_err1_code,
  input wire logic i_err2_valid,
  input wire logic i_iin_valid,
  input wire logic [mpp_pkg::IIN_W-1:0] i_iin_code,
  input wire logic [mpp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [mpp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [mpp_pkg::DATA_W-1:0] o_rdata,
  input wire mpp_pkg::mpp_pins_s o_pwm,
  input wire logic [mpp_pkg::ERR_W-1:0] o_err1,
  input wire logic [mpp_pkg::ERR_W-1:0] o_err2,
  input wire logic [mpp_pkg::MV_W-1:0] o_ref1_mv,
  input wire logic [15:0] o_iin_ma
);
  logic [15:0] ctrl_q;  // shadow of the control word
  logic [15:0] exp_iin; // expected current for the last sample
  logic [3:0] cfg_mask; // pins the configuration may drive
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // shadow control and expected current
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      ctrl_q <= 16'h0003;
    else if (i_wr && i_addr == 4'h0)
      ctrl_q <= i_wdata;
  end
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      exp_iin <= 16'h0000;
    else if (i_iin_valid)
      exp_iin <= 16'((32'(i_iin_code) * 32'd62500) >> (12 + ctrl_q[5:4]));
  end
  // allowed pins per configuration
  always_comb
  begin
    case (ctrl_q[2:0])
      3'h0: cfg_mask = 4'h7;
      3'h1: cfg_mask = 4'h3;
      3'h3: cfg_mask = 4'hf;
      3'h4: cfg_mask = 4'hb;
      3'h5: cfg_mask = 4'h9;
      default: cfg_mask = 4'h1;
    endcase
  end
  a_float_when_off: assert property (!i_en |=> o_pwm.oe == 4'h0)
    else $error("pins driven while disabled");
  a_oe_needs_en: assert property ($rose(o_pwm.oe[0]) |-> $past(i_en))
    else $error("drive began without enable");
  a_cfg_mask_kept: assert property ((o_pwm.oe & ~cfg_mask) == 4'h0)
    else $error("pin outside configuration driven");
  a_err1_capture: assert property (i_err1_valid |=> o_err1 == $past(i_err1_code))
    else $error("error word one not captured");
  a_err2_hold: assert property (!i_err2_valid |=> $stable(o_err2))
    else $error("error word two moved without sample");
  a_iin_scaled: assert property (i_iin_valid ##3 1 |-> o_iin_ma == exp_iin)
    else $error("input current scaled wrong");
  a_ref_slew_step: assert property ($changed(o_ref1_mv) |->
    o_ref1_mv == $past(o_ref1_mv) + 12'h001 || o_ref1_mv == $past(o_ref1_mv) - 12'h001)
    else $error("reference jumped");
  a_ref_dwell: assert property ($changed(o_ref1_mv) |=> $stable(o_ref1_mv) [*8])
    else $error("reference stepped too fast");
  a_unmapped_zero: assert property (i_rd && i_addr == 4'hf |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind mpp_top mpp_top_asserts chk_u (.*);

// *** verification/mpp_driver_model.sv ***
/*
  tri-state driver stages on the four pwm pins, with detection comparator.
  assumes unpopulated pins are grounded on the board.
*/
`timescale 1ns/10ps
module mpp_driver_model #(
  parameter logic [3:0] POPULATED = 4'hb
) (
  input wire mpp_pkg::mpp_pins_s i_pwm,
  output logic [3:0] o_present
);
  // floating populated pin reads high, grounded pin low
  always_comb
  begin
    o_present = (i_pwm.oe & i_pwm.level) | (~i_pwm.oe & POPULATED);
  end
endmodule

// *** verification/multiphase_pwm_phasing_test.sv ***
/*
  bench for the phasing block: registers, pins, converters, ramp.
  assumes the driver model on the pins and a 40 MHz clock.
*/
`timescale 1ns/10ps
module multiphase_pwm_phasing_test;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_en = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
  logic i_err1_valid = 1'b0, i_err2_valid = 1'b0, i_iin_valid = 1'b0;
  logic [3:0] i_pwm_present, i_addr = 4'h0;
  logic [7:0] i_duty1 = 8'h01, i_duty2 = 8'h01;
  logic [9:0] i_err1_code = 10'h000, i_err2_code = 10'h000, o_err1, o_err2;
  logic [11:0] i_iin_code = 12'h000, o_ref1_mv, o_ref2_mv;
  logic [15:0] i_wdata = 16'h0000, o_rdata, o_iin_ma;
  logic [31:0] c, e, x, exp_q[$]; // read notes are {mask, data}
  logic [3:0] oe_tab [8] = '{4'h7, 4'h3, 4'h1, 4'hf, 4'hb, 4'h9, 4'hb, 4'h3};
  logic [3:0] cf_tab [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb, 4'h8};
  mpp_pkg::mpp_pins_s o_pwm;
  int failures = 0, n_compared = 0, i, n, g;
  mpp_top dut_u (.*);
  mpp_driver_model #(.POPULATED(4'hb)) drv_u (.i_pwm(o_pwm), .o_present(i_pwm_present));
  initial
  begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    n_compared++;
    if ((got & m) !== (exp & m))
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // read results are compared the cycle after the strobe
  always @(posedge i_clk_sys)
  begin
    if (rd_seen)
    begin
      x = exp_q.pop_front();
      check(o_rdata, x[15:0], x[31:16]);
    end
    rd_seen <= i_rd;
  end
  task wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] m);
    exp_q.push_back({m, d});
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // cycles from a rising level on pin a to the next one on pin b, -1 if none
  task gap(input int a, input int b, output int t);
    logic [3:0] p, r;
    int s, k;
    s = 0;
    t = 0;
    p = o_pwm.level;
    for (k = 0; k < 200 && s < 2; k++)
    begin
      @(posedge i_clk_sys);
      r = o_pwm.level & ~p;
      p = o_pwm.level;
      if (s == 1)
        t++;
      if (s == 1 && r[b])
        s = 2;
      if (s == 0 && r[a])
        s = 1;
    end
    if (s < 2)
      t = -1;
  endtask
  // bounded wait on the pin enables (w=0) or reference one (w=1)
  task waitv(input int w, input logic [15:0] v);
    int k;
    for (k = 0; k < 25000 && (w ? 16'(o_ref1_mv) : 16'(o_pwm.oe)) !== v; k++)
      @(posedge i_clk_sys);
    if (k == 25000)
    begin
      failures++;
      $display("[FAIL] %0t wait ran out", $time);
      test_done();
    end
  endtask
  task test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    void'($urandom(31163));
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    i_en <= 1'b1;
    @(posedge i_clk_sys);
    // reset values, read-only status, unmapped place
    rd(4'h0, 16'h0003, 16'hffff);
    rd(4'h1, 16'h0064, 16'hffff);
    rd(4'h2, 16'h0064, 16'hffff);
    wr(4'h5, 16'h0000);
    wr(4'hf, 16'hffff);
    rd(4'h5, 16'h018b, 16'h0f8f);
    rd(4'hf, 16'h0000, 16'hffff);
    // target decode on both loops, ends and random codes
    for (i = 0; i < 8; i++)
    begin
      n = (i < 2) ? i : (i == 2) ? 255 : 1 + $urandom % 254;
      wr(4'h3, 16'(n));
      wr(4'h4, 16'(255 - n));
      rd(4'h6, 16'(n ? 490 + 10 * n : 0), 16'hffff);
      rd(4'h7, 16'(n < 255 ? 490 + 10 * (255 - n) : 0), 16'hffff);
    end
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h1, 16'd12);
    wr(4'h2, 16'd9);
    // every configuration by hand, CFG_3P1 and CFG_3P0 also detected
    for (i = 0; i < 8; i++)
    begin
      i_duty1 <= 8'(1 + $urandom % 10);
      i_duty2 <= 8'(1 + $urandom % 7);
      wr(4'h0, {9'h000, 1'b1, 2'h0, cf_tab[i]});
      repeat (4) @(posedge i_clk_sys);
      check(16'(o_pwm.oe), 16'(oe_tab[i]), 16'h000f);
      n = $countones(oe_tab[i][2:0]);
      gap(0, 0, g);
      check(16'(g), 16'd12, 16'hffff);
      if (n > 1)
      begin
        gap(0, 1, g);
        check(16'(g), 16'(12 / n), 16'hffff);
      end
      if (n > 2)
      begin
        gap(0, 2, g);
        check(16'(g), 16'd8, 16'hffff);
      end
      if (oe_tab[i][3])
      begin
        gap(3, 3, g);
        check(16'(g), 16'd9, 16'hffff);
      end
      rd(4'h5, 16'({4'h4, 1'b1, oe_tab[i][3], 2'(n), 4'hb}), 16'h0fff);
      if (i == 7)
      begin
        i_en <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        check(16'(o_pwm.oe), 16'h0000, 16'h000f);
        i_en <= 1'b1;
      end
      wr(4'h0, {12'h000, cf_tab[i]});
      waitv(0, 16'h0000);
    end
    // converters over all four current ranges
    for (i = 0; i < 4; i++)
    begin
      wr(4'h0, 16'(16'h0003 | (i << 4)));
      c = $urandom;
      e = (32'(c[31:20]) * 32'd62500) >> (12 + i);
      i_err1_code <= c[9:0];
      i_err2_code <= c[19:10];
      i_iin_code <= c[31:20];
      {i_err1_valid, i_err2_valid, i_iin_valid} <= 3'h7;
      @(posedge i_clk_sys);
      {i_err1_valid, i_err2_valid, i_iin_valid} <= 3'h0;
      repeat (3) @(posedge i_clk_sys);
      check(16'(o_err1), 16'(c[9:0]), 16'h03ff);
      check(16'(o_err2), 16'(c[19:10]), 16'h03ff);
      check(o_iin_ma, e[15:0], 16'hffff);
      rd(4'h9, 16'(c[19:10]), 16'h03ff);
      rd(4'ha, e[15:0], 16'hffff);
    end
    // soft-start to 500 mV, then shut-down ramp
    wr(4'h3, 16'h0001);
    wr(4'h4, 16'h0001);
    wr(4'h0, 16'h0043);
    waitv(1, 16'd500);
    check(16'(o_ref2_mv), 16'd500, 16'hffff);
    rd(4'h5, 16'h0400, 16'h0f00);
    wr(4'h0, 16'h0003);
    check(16'(o_pwm.oe), 16'h000f, 16'h000f);
    waitv(0, 16'h0000);
    check(16'(o_ref1_mv), 16'h0000, 16'hffff);
    rd(4'h5, 16'h0100, 16'h0f00);
    test_done();
  end
endmodule
